// ==== common/ds3rfa_consts.vh ====
`ifndef DS3RFA_CONSTS_VH
`define DS3RFA_CONSTS_VH

// ----------------------------------------
// Frame geometry
// ----------------------------------------
`define DS3RFA_POS_LAST 7'h54
`define DS3RFA_SLOT_LAST 3'h7
`define DS3RFA_SF_LAST 3'h6
`define DS3RFA_F1_SLOT 3'h1
`define DS3RFA_F4_SLOT 3'h7
`define DS3RFA_X2_SF 3'h1
`define DS3RFA_M1_SF 3'h4
`define DS3RFA_M2_SF 3'h5
`define DS3RFA_M3_SF 3'h6

// ----------------------------------------
// Subframe search
// ----------------------------------------
`define DS3RFA_PH_LAST 8'ha9
`define DS3RFA_PH_MOD 8'haa
`define DS3RFA_GROUP 8'h04
`define DS3RFA_FPAT 4'h9
`define DS3RFA_F_FILL 4'h4
`define DS3RFA_F_WIN 4'h8

// ----------------------------------------
// Multiframe search
// ----------------------------------------
`define DS3RFA_MPAT 3'h2
`define DS3RFA_M_FILL 5'h02
`define DS3RFA_MF_TMO 5'h0f

// ----------------------------------------
// Loss-of-alignment thresholds
// ----------------------------------------
`define DS3RFA_OOF_ERR 5'h03
`define DS3RFA_MULTIFRAME_LOSS_FLAG_ERR 3'h2
`define DS3RFA_FHIST_RST 16'hffff
`define DS3RFA_MHIST_RST 4'hf

// ----------------------------------------
// Integration
// ----------------------------------------
`define DS3RFA_INT_RUN 4'h5
`define DS3RFA_UNST_RUN 4'h8

// ----------------------------------------
// Timing
// ----------------------------------------
`define DS3RFA_MAX_AVG_REFRAME_TIME_NS 1000000
`define DS3RFA_CLK_NS 5

`endif

// ==== hdl/ds3rfa_integrator.v ====
`timescale 1ns/1ps
`include "ds3rfa_consts.vh"

module ds3rfa_integrator #(
   parameter WIDTH = 2
) (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_b_i,
   input wire ce_i,
   input wire clr_i,
   // Received occurrences
   input wire smp_vld_i,
   input wire [WIDTH-1:0] smp_i,
   // Integrated result
   output reg [WIDTH-1:0] value_o,
   output reg unstable_o
);

   reg [WIDTH-1:0] prev_q;
   reg [3:0] run_q;
   reg [3:0] diff_q;
   wire same = (smp_i == prev_q);
   wire [3:0] run_d = same ? ((run_q == `DS3RFA_UNST_RUN) ? run_q : run_q + 4'h1) : 4'h1;
   wire odd = (smp_i != value_o) && !same;
   wire [3:0] diff_d = odd ? ((diff_q == `DS3RFA_UNST_RUN) ? diff_q : diff_q + 4'h1) : 4'h0;

   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_q <= {WIDTH{1'b0}};
         run_q <= 4'h0;
         diff_q <= 4'h0;
         value_o <= {WIDTH{1'b0}};
         unstable_o <= 1'b0;
      end else if (ce_i) begin
         if (clr_i) begin
            run_q <= 4'h0;
            diff_q <= 4'h0;
            unstable_o <= 1'b0;
         end else if (smp_vld_i) begin
            prev_q <= smp_i;
            run_q <= run_d;
            diff_q <= diff_d;
            if (run_d >= `DS3RFA_INT_RUN) begin
               value_o <= smp_i; // [R4]
            end
            // Clear is checked last: a clean run of five ends instability
            if (diff_d == `DS3RFA_UNST_RUN) begin
               unstable_o <= 1'b1; // [R5]
            end else if (run_d >= `DS3RFA_INT_RUN) begin
               unstable_o <= 1'b0; // [R6]
            end
         end
      end
   end

endmodule // ds3rfa_integrator

// ==== hdl/ds3rfa_aligner.v ====
// Summary of operation
// [R1] Bytes travel MSB first; serial bytes arrive in that same order.
// [R2] Received bytes are taken and re-emitted serially MSB first.
// [R3] First line bit of a byte lands in register bit 7, last in 0.
// [R4] Integrated value replaces stored only after five identical new receptions.
// [R5] Unstable after eight receptions each differing from stored and previous.
// [R6] Unstable ends once the same value is received five times running.
// [R7] Subframe boundary found by F-bits matching one, zero, zero, one.
// [R8] Multiframe boundary found by M-bits matching zero, one, zero.
// [R9] Search is off-line; counters load only during frame or multiframe loss.
// [R10] Four adjacent candidates checked at once; move on when all four fail.
// [R11] 170 candidate positions, covered in at most 43 four-wide checks.
// [R12] Multiframe search idles until subframe lock, then tests positions.
// [R13] Recheck multiframe every frame; load on clean M-bits while loss present.
// [R14] Seven multiframe positions, three M-bits, at most nine checks.
// [R15] Over fifteen multiframe bits examined without match: restart subframe load.
// [R16] Mean reframe time about 1.0 ms; overrun is flagged.
// [R17] Multiframe loss on M errors in two of last four frames or resync.
// [R18] Frame loss on three of sixteen F errors; optionally on multiframe loss.
// [R19] One bit per rising line clock edge; sync reset restarts both searches.
`timescale 1ns/1ps
`include "ds3rfa_consts.vh"

module ds3rfa_aligner #(
   parameter [31:0] MAX_AVG_REFRAME_TIME_CYC = `DS3RFA_MAX_AVG_REFRAME_TIME_NS / `DS3RFA_CLK_NS
) (
   // Clock, reset, enable
   input wire ref_clk_i,
   input wire rst_b_i,
   input wire ce_i,
   // Line side
   input wire rx_line_clk_i,
   input wire rx_line_data_in_i,
   // Control
   input wire soft_rst_i,
   input wire resync_req_i,
   input wire cfg_oof_on_mf_i,
   // Alignment status
   output reg frame_loss_flag_o,
   output reg multiframe_loss_flag_o,
   output wire sf_lock_o,
   output wire mf_lock_o,
   output reg reframe_slow_o,
   // Data out
   output reg rx_bit_stb_o,
   output reg rx_ser_o,
   output reg rx_oh_o,
   output reg [7:0] rx_byte_o,
   output reg rx_byte_vld_o,
   // Integrated overhead
   output wire [1:0] xbits_o,
   output wire xbits_unstable_o
);

   localparam [2:0] SF_LOAD = 3'b001;
   localparam [2:0] SF_SRCH = 3'b010;
   localparam [2:0] SF_LOCK = 3'b100;
   localparam [2:0] MF_IDLE = 3'b001;
   localparam [2:0] MF_SRCH = 3'b010;
   localparam [2:0] MF_SYNC = 3'b100;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Coordinates are {subframe, slot, position} of one bit
   function [12:0] nxt;
      input [12:0] c;
      begin
         nxt = c;
         if (c[6:0] != `DS3RFA_POS_LAST) begin
            nxt[6:0] = c[6:0] + 7'h01;
         end else begin
            nxt[6:0] = 7'h00;
            if (c[9:7] != `DS3RFA_SLOT_LAST) begin
               nxt[9:7] = c[9:7] + 3'h1;
            end else begin
               nxt[9:7] = 3'h0;
               nxt[12:10] = (c[12:10] == `DS3RFA_SF_LAST) ? 3'h0 : c[12:10] + 3'h1;
            end
         end
      end
   endfunction

   function [4:0] pop16;
      input [15:0] v;
      integer i;
      begin
         pop16 = 5'h00;
         for (i = 0; i < 16; i = i + 1) begin
            pop16 = pop16 + {4'h0, v[i]};
         end
      end
   endfunction

   // Any rotation of the F-bit pattern is a consistent window
   function win_ok;
      input [3:0] h;
      begin
         win_ok = (h == `DS3RFA_FPAT) || ({h[2:0], h[3]} == `DS3RFA_FPAT) ||
                  ({h[1:0], h[3:2]} == `DS3RFA_FPAT) || ({h[0], h[3:1]} == `DS3RFA_FPAT);
      end
   endfunction

   // ----------------------------------------
   // Line synchroniser
   // ----------------------------------------
   reg lclk_s1_q, lclk_s2_q, lclk_s3_q;
   reg ldat_s1_q, ldat_s2_q;

   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lclk_s1_q <= 1'b0;
         lclk_s2_q <= 1'b0;
         lclk_s3_q <= 1'b0;
         ldat_s1_q <= 1'b0;
         ldat_s2_q <= 1'b0;
      end else if (ce_i) begin
         lclk_s1_q <= rx_line_clk_i;
         lclk_s2_q <= lclk_s1_q;
         lclk_s3_q <= lclk_s2_q;
         ldat_s1_q <= rx_line_data_in_i;
         ldat_s2_q <= ldat_s1_q;
      end
   end

   wire adv = ce_i && lclk_s2_q && !lclk_s3_q; // [R19]
   wire bit_v = ldat_s2_q;

   // ----------------------------------------
   // Subframe candidate checkers
   // ----------------------------------------
   reg [2:0] sf_st_q, mf_st_q;
   reg [7:0] ph_q, base_q;
   wire [3:0] chk_fail, chk_found;
   wire chk_clr = (sf_st_q == SF_LOAD) || ((sf_st_q == SF_SRCH) && (&chk_fail)); // [R10]

   genvar k;
   generate
      for (k = 0; k < 4; k = k + 1) begin : g_chk
         reg [3:0] h_q, n_q;
         reg fail_q;
         wire [7:0] raw = base_q + k[7:0];
         wire [7:0] cand = (raw >= `DS3RFA_PH_MOD) ? raw - `DS3RFA_PH_MOD : raw;
         wire hit = adv && (ph_q == cand) && !fail_q && (sf_st_q == SF_SRCH);
         wire [3:0] h_d = {h_q[2:0], bit_v};
         wire full = (n_q + 4'h1 >= `DS3RFA_F_FILL);
         assign chk_fail[k] = fail_q;
         assign chk_found[k] = hit && (n_q + 4'h1 >= `DS3RFA_F_WIN) &&
                               (h_d == `DS3RFA_FPAT); // [R7]
         always @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               h_q <= 4'h0;
               n_q <= 4'h0;
               fail_q <= 1'b0;
            end else if (ce_i) begin
               if (chk_clr) begin
                  h_q <= 4'h0;
                  n_q <= 4'h0;
                  fail_q <= 1'b0;
               end else if (hit) begin
                  h_q <= h_d;
                  if (n_q != `DS3RFA_F_WIN) begin
                     n_q <= n_q + 4'h1;
                  end
                  if (full && !win_ok(h_d)) begin
                     fail_q <= 1'b1;
                  end
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Off-line search state
   // ----------------------------------------
   reg [12:0] sr_q;
   reg [2:0] mh_q;
   reg [4:0] mcnt_q;
   reg macc_q;
   reg dp_load_q;
   wire loss = frame_loss_flag_o || multiframe_loss_flag_o;
   wire m_samp = adv && (sr_q[9:0] == 10'h000);
   wire [2:0] mh_d = {mh_q[1:0], bit_v};
   wire m_exp = (sr_q[12:10] == `DS3RFA_M2_SF);
   wire m_err = (bit_v != m_exp) || macc_q;
   wire [7:0] base_nx = base_q + `DS3RFA_GROUP;

   assign sf_lock_o = (sf_st_q == SF_LOCK);
   assign mf_lock_o = (mf_st_q == MF_SYNC);

   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sf_st_q <= SF_LOAD;
         mf_st_q <= MF_IDLE;
         ph_q <= 8'h00;
         base_q <= 8'h00;
         sr_q <= 13'h0000;
         mh_q <= 3'h0;
         mcnt_q <= 5'h00;
         macc_q <= 1'b0;
         dp_load_q <= 1'b0;
      end else if (ce_i) begin
         dp_load_q <= 1'b0;
         if (adv) begin
            ph_q <= (ph_q == `DS3RFA_PH_LAST) ? 8'h00 : ph_q + 8'h01;
            sr_q <= nxt(sr_q);
         end
         if (soft_rst_i) begin
            sf_st_q <= SF_LOAD; // [R19]
            mf_st_q <= MF_IDLE;
         end else begin
            case (sf_st_q)
               SF_LOAD: begin
                  base_q <= 8'h00;
                  mf_st_q <= MF_IDLE;
                  sf_st_q <= SF_SRCH;
               end
               SF_SRCH: begin
                  mf_st_q <= MF_IDLE; // [R12]
                  if (|chk_found) begin
                     sf_st_q <= SF_LOCK;
                     mf_st_q <= MF_SRCH;
                     // Matching bit was F4; next bit is position 1 of that slot
                     sr_q <= {3'h0, `DS3RFA_F4_SLOT, 7'h01};
                     mh_q <= 3'h0;
                     mcnt_q <= 5'h00;
                  end else if (&chk_fail) begin
                     // Last group wraps past 169, giving 43 groups in all
                     base_q <= (base_nx >= `DS3RFA_PH_MOD) ? 8'h00 : base_nx; // [R11]
                  end
               end
               SF_LOCK: begin
                  case (mf_st_q)
                     MF_SRCH: begin
                        if (m_samp) begin
                           mh_q <= mh_d;
                           mcnt_q <= mcnt_q + 5'h01;
                           if ((mcnt_q >= `DS3RFA_M_FILL) && (mh_d == `DS3RFA_MPAT)) begin
                              mf_st_q <= MF_SYNC; // [R8] [R14]
                              macc_q <= 1'b0;
                              sr_q <= {`DS3RFA_M3_SF, 3'h0, 7'h01};
                              dp_load_q <= loss; // [R9]
                           end else if (mcnt_q == `DS3RFA_MF_TMO) begin
                              sf_st_q <= SF_LOAD; // [R15]
                              mf_st_q <= MF_IDLE;
                           end
                        end
                     end
                     MF_SYNC: begin
                        if (m_samp && (sr_q[12:10] >= `DS3RFA_M1_SF)) begin
                           macc_q <= m_err;
                           if (sr_q[12:10] == `DS3RFA_M3_SF) begin
                              macc_q <= 1'b0;
                              if (!m_err) begin
                                 dp_load_q <= loss; // [R13]
                              end else if (loss) begin
                                 // Stale alignment while data path is lost: search again
                                 sf_st_q <= SF_LOAD;
                                 mf_st_q <= MF_IDLE;
                              end
                           end
                        end
                     end
                     default: mf_st_q <= MF_IDLE;
                  endcase
               end
               default: sf_st_q <= SF_LOAD;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Data-path counters and loss flags
   // ----------------------------------------
   reg [12:0] dp_q;
   reg [15:0] fh_q;
   reg [3:0] mh4_q;
   reg dacc_q;
   wire oh = (dp_q[6:0] == 7'h00);
   wire [2:0] dslot = dp_q[9:7];
   wire [2:0] dsf = dp_q[12:10];
   wire f_chk = adv && oh && dslot[0];
   wire f_exp = (dslot == `DS3RFA_F1_SLOT) || (dslot == `DS3RFA_F4_SLOT);
   wire [15:0] fh_d = {fh_q[14:0], bit_v != f_exp};
   wire m_chk = adv && oh && (dslot == 3'h0) && (dsf >= `DS3RFA_M1_SF);
   wire dm_err = (bit_v != (dsf == `DS3RFA_M2_SF)) || dacc_q;
   wire m_push = m_chk && (dsf == `DS3RFA_M3_SF);
   wire [3:0] mh4_d = {mh4_q[2:0], dm_err};
   wire [2:0] mh4_cnt = {2'h0, mh4_d[0]} + {2'h0, mh4_d[1]} + {2'h0, mh4_d[2]} +
                        {2'h0, mh4_d[3]};
   wire mf_gate = cfg_oof_on_mf_i && multiframe_loss_flag_o;

   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dp_q <= 13'h0000;
         fh_q <= `DS3RFA_FHIST_RST;
         mh4_q <= `DS3RFA_MHIST_RST;
         dacc_q <= 1'b0;
         frame_loss_flag_o <= 1'b1;
         multiframe_loss_flag_o <= 1'b1;
      end else if (ce_i) begin
         if (dp_load_q) begin
            // Strobes are several clocks apart, so no bit is skipped here
            dp_q <= {`DS3RFA_M3_SF, 3'h0, 7'h01}; // [R9]
            dacc_q <= 1'b0;
         end else if (adv) begin
            dp_q <= nxt(dp_q);
            if (f_chk) begin
               fh_q <= fh_d;
            end
            if (m_chk) begin
               dacc_q <= m_push ? 1'b0 : dm_err;
            end
            if (m_push) begin
               mh4_q <= mh4_d;
            end
         end
         // Set wins over clear for both flags
         if (resync_req_i || (m_push && (mh4_cnt >= `DS3RFA_MULTIFRAME_LOSS_FLAG_ERR))) begin
            multiframe_loss_flag_o <= 1'b1; // [R17]
         end else if (dp_load_q || (m_push && (mh4_d == 4'h0))) begin
            multiframe_loss_flag_o <= 1'b0;
         end
         if (resync_req_i || mf_gate || (f_chk && (pop16(fh_d) >= `DS3RFA_OOF_ERR))) begin
            frame_loss_flag_o <= 1'b1; // [R18]
         end else if (dp_load_q || (f_chk && (fh_d == 16'h0000))) begin
            frame_loss_flag_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Serial and byte output
   // ----------------------------------------
   reg [6:0] bsh_q;
   reg [2:0] bcnt_q;
   reg [31:0] rf_cnt_q;

   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bsh_q <= 7'h00;
         bcnt_q <= 3'h0;
         rx_bit_stb_o <= 1'b0;
         rx_ser_o <= 1'b0;
         rx_oh_o <= 1'b0;
         rx_byte_o <= 8'h00;
         rx_byte_vld_o <= 1'b0;
         rf_cnt_q <= 32'h0000_0000;
         reframe_slow_o <= 1'b0;
      end else if (ce_i) begin
         rx_bit_stb_o <= adv;
         rx_byte_vld_o <= 1'b0;
         if (adv) begin
            rx_ser_o <= bit_v; // [R2] [R1]
            rx_oh_o <= oh;
         end
         if (dp_load_q) begin
            bcnt_q <= 3'h0;
         end else if (adv && !oh) begin
            bsh_q <= {bsh_q[5:0], bit_v};
            bcnt_q <= bcnt_q + 3'h1;
            if (bcnt_q == 3'h7) begin
               rx_byte_o <= {bsh_q, bit_v}; // [R3]
               rx_byte_vld_o <= 1'b1;
            end
         end
         // Reframe watchdog; one long outage is only a hint against the average
         if (!frame_loss_flag_o) begin
            rf_cnt_q <= 32'h0000_0000;
            reframe_slow_o <= 1'b0;
         end else if (rf_cnt_q != MAX_AVG_REFRAME_TIME_CYC) begin
            rf_cnt_q <= rf_cnt_q + 32'h0000_0001;
         end else begin
            reframe_slow_o <= 1'b1; // [R16]
         end
      end
   end

   // ----------------------------------------
   // X-bit integration
   // ----------------------------------------
   reg x1_q;
   wire x_pos = adv && !dp_load_q && oh && (dslot == 3'h0);
   wire x2_vld = x_pos && (dsf == `DS3RFA_X2_SF);

   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         x1_q <= 1'b0;
      end else if (ce_i && x_pos && (dsf == 3'h0)) begin
         x1_q <= bit_v;
      end
   end

   ds3rfa_integrator #(
      .WIDTH(2)
   ) u_xint (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .clr_i(soft_rst_i),
      .smp_vld_i(x2_vld),
      .smp_i({x1_q, bit_v}),
      .value_o(xbits_o),
      .unstable_o(xbits_unstable_o)
   );

endmodule // ds3rfa_aligner

// ==== bench/ds3rfa_aligner_checker.sv ====
`timescale 1ns/1ps

module ds3rfa_aligner_checker #(
   parameter [31:0] MAX_AVG_REFRAME_TIME_CYC = 32'd200000
) (
   // Clock, reset, enable
   input logic ref_clk_i,
   input logic rst_b_i,
   input logic ce_i,
   // Control
   input logic soft_rst_i,
   input logic resync_req_i,
   input logic cfg_oof_on_mf_i,
   // Status
   input logic frame_loss_flag_o,
   input logic multiframe_loss_flag_o,
   input logic sf_lock_o,
   input logic mf_lock_o,
   input logic reframe_slow_o,
   // Data
   input logic rx_bit_stb_o,
   input logic rx_ser_o,
   input logic rx_oh_o,
   input logic [7:0] rx_byte_o,
   input logic rx_byte_vld_o
);
   default clocking dcb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   // ----------------------------------------
   // Frame loss duration
   // ----------------------------------------
   logic [31:0] loss_cyc_q;
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         loss_cyc_q <= 32'h0;
      end else if (!frame_loss_flag_o) begin
         loss_cyc_q <= 32'h0;
      end else if (ce_i && loss_cyc_q != 32'hffffffff) begin
         loss_cyc_q <= loss_cyc_q + 32'h1;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   stb_pulse_a: assert property (rx_bit_stb_o |=> !rx_bit_stb_o [*3])
      else $error("bit strobe not a lone pulse");
   byte_payload_a: assert property (rx_byte_vld_o |-> rx_bit_stb_o && !rx_oh_o)
      else $error("byte completed off a payload bit");
   byte_last_bit_a: assert property (rx_byte_vld_o |-> rx_byte_o[0] == rx_ser_o)
      else $error("last line bit not in byte bit 0");
   sf_lock_f4_a: assert property ($rose(sf_lock_o) |-> rx_bit_stb_o && rx_ser_o)
      else $error("subframe lock not on a one F bit");
   mf_lock_m3_a: assert property ($rose(mf_lock_o) |-> rx_bit_stb_o && !rx_ser_o)
      else $error("multiframe lock not on a zero M bit");
   mf_needs_sf_a: assert property (mf_lock_o |-> sf_lock_o)
      else $error("multiframe lock without subframe lock");
   resync_set_a: assert property (resync_req_i && ce_i |=> frame_loss_flag_o && multiframe_loss_flag_o)
      else $error("resync did not set both loss flags");
   mf_forces_oof_a: assert property (cfg_oof_on_mf_i && multiframe_loss_flag_o && ce_i
      |=> frame_loss_flag_o)
      else $error("multiframe loss did not force frame loss");
   soft_rst_a: assert property (soft_rst_i && ce_i |=> !sf_lock_o && !mf_lock_o)
      else $error("soft reset left a search locked");
   slow_late_a: assert property (loss_cyc_q > MAX_AVG_REFRAME_TIME_CYC + 32'd2 |-> reframe_slow_o)
      else $error("slow reframe not flagged");
   slow_early_a: assert property ($rose(reframe_slow_o) |->
      loss_cyc_q + 32'd3 >= MAX_AVG_REFRAME_TIME_CYC)
      else $error("slow reframe flagged too early");

   // ----------------------------------------
   // Coverage
   // ----------------------------------------
   sf_lock_c: cover property ($rose(sf_lock_o));
   mf_lock_c: cover property ($rose(mf_lock_o));
   byte_c: cover property (rx_byte_vld_o);
   oof_clear_c: cover property ($fell(frame_loss_flag_o));
endmodule // ds3rfa_aligner_checker

bind ds3rfa_aligner ds3rfa_aligner_checker #(
   .MAX_AVG_REFRAME_TIME_CYC(MAX_AVG_REFRAME_TIME_CYC)
) ds3rfa_aligner_checker_i (
   .ref_clk_i, .rst_b_i, .ce_i, .soft_rst_i, .resync_req_i, .cfg_oof_on_mf_i,
   .frame_loss_flag_o, .multiframe_loss_flag_o, .sf_lock_o, .mf_lock_o, .reframe_slow_o,
   .rx_bit_stb_o, .rx_ser_o, .rx_oh_o, .rx_byte_o, .rx_byte_vld_o
);

// ==== bench/ds3rfa_line_src.sv ====
`timescale 1ns/1ps

module ds3rfa_line_src #(
   parameter logic [7:0] PAY_BYTE = 8'h2d,
   parameter int START_BIT = 83
) (
   // Control
   input logic run_i,
   // Line side
   output logic line_clk_o,
   output logic line_dat_o
);
   // ----------------------------------------
   // Line bit at frame position fb
   // ----------------------------------------
   function automatic logic bit_at(input int fb);
      int sf;
      int sl;
      int p;
      sf = fb / 680;
      sl = (fb % 680) / 85;
      p = fb % 85;
      if (p != 0) begin
         bit_at = PAY_BYTE[7 - ((sf * 672 + sl * 84 + p - 1) % 8)];
      end else if (sl % 2 == 1) begin
         bit_at = (sl == 1) || (sl == 7);
      end else if (sl == 0) begin
         bit_at = (sf == 0) || (sf == 5);
      end else begin
         bit_at = 1'b0;
      end
   endfunction

   // ----------------------------------------
   // Line generator
   // ----------------------------------------
   initial begin : gen_line
      int fb;
      fb = START_BIT;
      line_clk_o = 1'b0;
      line_dat_o = 1'b0;
      // Idle: clock still, data wanders so no stale level looks like a bit
      while (!run_i) begin
         #7 line_dat_o = ~line_dat_o;
      end
      // Data moves on the falling edge, clear of the rising one
      forever begin
         line_dat_o = bit_at(fb);
         #12.5 line_clk_o = 1'b1;
         #12.5 line_clk_o = 1'b0;
         fb = (fb + 1) % 4760;
      end
   end
endmodule // ds3rfa_line_src

// ==== bench/ds3rfa_aligner_tb.sv ====
`timescale 1ns/1ps

module ds3rfa_aligner_tb;
   localparam [31:0] SLOW_CYC = 32'd200;
   localparam int TMO_CYC = 90000;
   localparam logic [7:0] PAY = 8'h2d;

   logic ref_clk, rst_b, ce, soft_rst, resync, cfg_oof, src_run, line_clk, line_dat;
   logic fll, mfl, sf_lock, mf_lock, slow, stb, ser, oh, bvld, xuns;
   logic [7:0] rbyte;
   logic [1:0] xbits;
   int failures = 0;
   int compares = 0;
   int cyc = 0;
   int n, nb, i;
   // Control rows with an idle line: soft reset, resync, mf-to-oof, then
   // expected frame loss, multiframe loss, subframe lock, multiframe lock
   logic [6:0] rows [0:3] = '{7'b1001100, 7'b0101100, 7'b0011100, 7'b0001100};

   // ----------------------------------------
   // Instances
   // ----------------------------------------
   ds3rfa_aligner #(.MAX_AVG_REFRAME_TIME_CYC(SLOW_CYC)) ds3rfa_aligner_i (
      .ref_clk_i(ref_clk), .rst_b_i(rst_b), .ce_i(ce),
      .rx_line_clk_i(line_clk), .rx_line_data_in_i(line_dat),
      .soft_rst_i(soft_rst), .resync_req_i(resync), .cfg_oof_on_mf_i(cfg_oof),
      .frame_loss_flag_o(fll), .multiframe_loss_flag_o(mfl), .sf_lock_o(sf_lock),
      .mf_lock_o(mf_lock), .reframe_slow_o(slow), .rx_bit_stb_o(stb), .rx_ser_o(ser),
      .rx_oh_o(oh), .rx_byte_o(rbyte), .rx_byte_vld_o(bvld), .xbits_o(xbits),
      .xbits_unstable_o(xuns));
   ds3rfa_line_src #(.PAY_BYTE(PAY)) ds3rfa_line_src_i (
      .run_i(src_run), .line_clk_o(line_clk), .line_dat_o(line_dat));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task final_report;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Clock and watchdog
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == TMO_CYC) begin
         failures++;
         final_report();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      soft_rst = 1'b0;
      resync = 1'b0;
      cfg_oof = 1'b0;
      src_run = 1'b0;
      repeat (10) @(negedge ref_clk);
      chk_val({fll, mfl, sf_lock, mf_lock, slow, stb, bvld, xuns}, 8'hc0);
      chk_val({5'h0, xuns, xbits}, 8'h00);
      rst_b = 1'b1;
      repeat (2) @(negedge ref_clk);
      for (i = 0; i < 4; i++) begin
         {soft_rst, resync, cfg_oof} = rows[i][6:4];
         @(negedge ref_clk);
         {soft_rst, resync, cfg_oof} = 3'h0;
         chk_val({4'h0, fll, mfl, sf_lock, mf_lock}, {4'h0, rows[i][3:0]});
      end
      chk_val({5'h0, xuns, xbits}, 8'h00);
      src_run = 1'b1;
      for (n = 0; n < 30000 && sf_lock !== 1'b1; n++) @(negedge ref_clk);
      chk_bit(sf_lock, 1'b1);
      chk_bit(mf_lock, 1'b0);
      for (n = 0; n < 30000 && mf_lock !== 1'b1; n++) @(negedge ref_clk);
      chk_bit(mf_lock, 1'b1);
      repeat (3) @(negedge ref_clk);
      chk_val({6'h0, fll, mfl}, 8'h00);
      // Payload run after the multiframe bit, up to the next overhead bit
      nb = 0;
      for (n = 0; n < 1000 && !(stb === 1'b1 && oh === 1'b1); n++) begin
         @(negedge ref_clk);
         if (stb === 1'b1 && oh === 1'b0) nb++;
         if (bvld === 1'b1) chk_val(rbyte, PAY);
      end
      chk_val(nb[7:0], 8'h54);
      resync = 1'b1;
      cfg_oof = 1'b1;
      @(negedge ref_clk);
      resync = 1'b0;
      cfg_oof = 1'b0;
      chk_val({6'h0, fll, mfl}, 8'h03);
      repeat (300) @(negedge ref_clk);
      chk_bit(slow, 1'b1);
      for (n = 0; n < 26000 && (fll !== 1'b0 || mfl !== 1'b0); n++) @(negedge ref_clk);
      chk_val({5'h0, fll, mfl, mf_lock}, 8'h01);
      soft_rst = 1'b1;
      @(negedge ref_clk);
      soft_rst = 1'b0;
      chk_val({4'h0, sf_lock, mf_lock, fll, mfl}, 8'h00);
      rst_b = 1'b0;
      #1;
      chk_val({4'h0, fll, mfl, sf_lock, mf_lock}, 8'h0c);
      final_report();
   end
endmodule // ds3rfa_aligner_tb
